// file: hdl/sbi_requester.sv
// Bus interrupt requester: request latch, ack phases, vector drive
`timescale 1ns/10ps

module sbi_requester
  import sbi_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    bus_vectored_mode,
  input  wire logic                    request_port_write,
  input  wire logic [SBI_PORT_W-1:0]   local_addr_low_bits,
  input  wire logic                    vector_write,
  input  wire logic [SBI_VECTOR_W-1:0] vector_data,
  input  wire logic                    local_io_read_active,
  input  wire logic                    local_io_write_active,
  input  wire logic                    bus_ack_strobe_n,
  input  wire logic                    bus_ack_return_n,
  input  wire logic [SBI_LEVEL_W-1:0]  bus_level_code,
  output logic [SBI_LINES-1:0]         bus_int_n_o,
  output logic [SBI_LINES-1:0]         bus_int_n_oe,
  output logic [SBI_VECTOR_W-1:0]      bus_data_o,
  output logic [SBI_VECTOR_W-1:0]      bus_data_oe,
  output logic                         ack_drive_n_o,
  output logic                         ack_drive_n_oe,
  output logic                         request_clear,
  output logic                         vector_drive_active,
  output logic [1:0]                   ack_phase
);

  // ----------------------------------------
  // Bus input synchronisers
  // ----------------------------------------
  sbi_bus_ack_t bus_raw;
  sbi_bus_ack_t bus_s;

  assign bus_raw = '{buffered_ack_strobe: ~bus_ack_strobe_n,
                     ack_return_seen:     ~bus_ack_return_n,
                     bus_level_code:      bus_level_code};

  sbi_sync #(.WIDTH($bits(sbi_bus_ack_t))) u_bus_sync (
    .clk         (clk),
    .reset       (reset),
    .clear_first (1'b0),
    .din         (bus_raw),
    .dout        (bus_s)
  );

  wire logic strobe;
  wire logic ret_seen;
  assign strobe   = bus_s.buffered_ack_strobe;
  assign ret_seen = bus_s.ack_return_seen;

  // ----------------------------------------
  // Request latch and fresh-request flag
  // ----------------------------------------
  logic [SBI_PORT_W-1:0]   port_reg;
  logic                    fresh_reg;
  logic                    strobe_seen_reg;
  logic                    change_pulse;
  logic                    request_change_pulse;
  logic [SBI_VECTOR_W-1:0] vector_reg;
  logic                    vec_en_reg;
  sbi_ack_state_t          ack_state_reg;
  sbi_ack_state_t          ack_state_next;

  wire logic phase_one;
  wire logic phase_two;
  wire logic phase_three;
  assign phase_one   = (ack_state_reg == SBI_ACK_ONE) ||
                       (ack_state_reg == SBI_ACK_TWO) ||
                       (ack_state_reg == SBI_ACK_THREE);
  assign phase_two   = (ack_state_reg == SBI_ACK_TWO) ||
                       (ack_state_reg == SBI_ACK_THREE);
  assign phase_three = (ack_state_reg == SBI_ACK_THREE);

  // Request-clear is combinational so it acts in the same cycle
  assign request_clear = reset || (vec_en_reg && !strobe);

  // Data ignored on purpose: the address itself is the request
  always_ff @(posedge clk) begin
    if (request_clear) begin
      port_reg <= SBI_PORT_RESET;
    end else if (request_port_write) begin
      port_reg <= local_addr_low_bits;
    end
  end

  // Set wins over the change-pulse clear
  always_ff @(posedge clk) begin
    if (reset) begin
      fresh_reg <= 1'b0;
    end else if (request_port_write) begin
      fresh_reg <= 1'b1;
    end else if (request_change_pulse) begin
      fresh_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Apply-enable and change pulse
  // ----------------------------------------
  wire logic apply_mode_ok;
  wire logic apply_enable;
  wire logic apply_sync;
  wire logic plain_line_mode;

  assign plain_line_mode = !bus_vectored_mode;
  assign apply_mode_ok   = plain_line_mode ||
                           (!phase_one && !phase_three);
  assign apply_enable    = fresh_reg && !request_port_write &&
                           !reset && apply_mode_ok;

  sbi_sync #(.WIDTH(1)) u_apply_sync (
    .clk         (clk),
    .reset       (reset),
    .clear_first (request_change_pulse),
    .din         (apply_enable),
    .dout        (apply_sync)
  );

  // One-cycle pulse from the synchronised level
  always_ff @(posedge clk) begin
    if (reset) begin
      strobe_seen_reg <= 1'b0;
    end else begin
      strobe_seen_reg <= apply_sync;
    end
  end

  assign change_pulse         = apply_sync && !strobe_seen_reg;
  assign request_change_pulse = change_pulse;

  // ----------------------------------------
  // Output latch
  // ----------------------------------------
  sbi_request_t            req_word;
  wire logic               off_blocked;
  wire logic               latch_load;
  logic [SBI_LINES-1:0]    lines;

  assign req_word.request_on_bit = port_reg[SBI_ON_BIT];
  assign req_word.level_code     = port_reg[SBI_LEVEL_LSB +: SBI_LEVEL_W];
  // Off requests do nothing in vectored mode
  assign off_blocked = bus_vectored_mode && !req_word.request_on_bit;
  assign latch_load  = request_change_pulse && !off_blocked;

  sbi_addr_latch u_latch (
    .clk   (clk),
    .clear (request_clear),
    .load  (latch_load),
    .req   (req_word),
    .lines (lines)
  );

  // Open-collector lines: drive low only when a line is on
  assign bus_int_n_o  = SBI_LINES_RESET;
  assign bus_int_n_oe = lines;

  // ----------------------------------------
  // Acknowledge phase tracker
  // ----------------------------------------
  always_comb begin
    ack_state_next = ack_state_reg;
    case (ack_state_reg)
      SBI_ACK_IDLE: begin
        if (strobe) begin
          ack_state_next = SBI_ACK_ONE;
        end
      end
      SBI_ACK_ONE: begin
        if (ret_seen) begin
          ack_state_next = SBI_ACK_IDLE;
        end else if (!strobe) begin
          ack_state_next = SBI_ACK_TWO;
        end
      end
      SBI_ACK_TWO: begin
        if (ret_seen) begin
          ack_state_next = SBI_ACK_IDLE;
        end else if (strobe) begin
          ack_state_next = SBI_ACK_THREE;
        end
      end
      SBI_ACK_THREE: begin
        // Return ends phases one and two; three lives on the strobe
        if (!strobe) begin
          ack_state_next = ret_seen ? SBI_ACK_IDLE : SBI_ACK_TWO;
        end
      end
      default: begin
        ack_state_next = SBI_ACK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_state_reg <= SBI_ACK_IDLE;
    end else begin
      ack_state_reg <= ack_state_next;
    end
  end

  // ----------------------------------------
  // Vector latch and vector drive
  // ----------------------------------------
  // No reset: software must load it before a vectored request
  always_ff @(posedge clk) begin
    if (vector_write) begin
      vector_reg <= vector_data;
    end
  end

  wire logic level_match;
  wire logic vec_set;
  assign level_match = (bus_s.bus_level_code == req_word.level_code);
  assign vec_set     = phase_three && req_word.request_on_bit &&
                       bus_vectored_mode && level_match &&
                       !fresh_reg;

  always_ff @(posedge clk) begin
    if (request_clear) begin
      vec_en_reg <= 1'b0;
    end else if (vec_set) begin
      vec_en_reg <= 1'b1;
    end
  end

  logic [SBI_VECTOR_W-1:0] data_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      data_reg <= '0;
    end else begin
      data_reg <= vector_reg;
    end
  end

  assign bus_data_o  = vec_en_reg ? data_reg : '0;
  assign bus_data_oe = {SBI_VECTOR_W{vec_en_reg}};

  // ----------------------------------------
  // Transfer acknowledge
  // ----------------------------------------
  wire logic ack_drive;
  assign ack_drive = local_io_read_active || local_io_write_active ||
                     (vec_en_reg && strobe);
  assign ack_drive_n_o  = 1'b0;
  assign ack_drive_n_oe = ack_drive;

  assign vector_drive_active = vec_en_reg;
  assign ack_phase = ack_state_reg;

endmodule : sbi_requester

// file: common/sbi_pkg.sv
// Package: constants and carrier types for the bus interrupt requester
package sbi_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int SBI_LINES      = 8;
  localparam int SBI_LEVEL_W    = 3;
  localparam int SBI_PORT_W     = 4;
  localparam int SBI_VECTOR_W   = 8;
  localparam int SBI_SYNC_DEPTH = 2;

  // ----------------------------------------
  // Request port field layout
  // ----------------------------------------
  localparam int SBI_ON_BIT     = 3;
  localparam int SBI_LEVEL_LSB  = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] SBI_PORT_RESET  = 4'h0;
  localparam logic [7:0] SBI_LINES_RESET = 8'h00;

  // ----------------------------------------
  // Acknowledge tracker states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SBI_ACK_IDLE  = 2'b00,
    SBI_ACK_ONE   = 2'b01,
    SBI_ACK_TWO   = 2'b11,
    SBI_ACK_THREE = 2'b10
  } sbi_ack_state_t;

  // Latched request: on/off bit and line number
  typedef struct packed {
    logic       request_on_bit;
    logic [2:0] level_code;
  } sbi_request_t;

  // Bus side acknowledge inputs
  typedef struct packed {
    logic       buffered_ack_strobe;
    logic       ack_return_seen;
    logic [2:0] bus_level_code;
  } sbi_bus_ack_t;

endpackage : sbi_pkg

// file: hdl/sbi_sync.sv
// Two flip-flop synchroniser with clear of the first stage
`timescale 1ns/10ps
module sbi_sync
  import sbi_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clear_first,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] first_reg;
  logic [WIDTH-1:0] second_reg;

  always_ff @(posedge clk) begin
    if (reset || clear_first) begin
      first_reg <= '0;
    end else begin
      first_reg <= din;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      second_reg <= '0;
    end else begin
      second_reg <= first_reg;
    end
  end

  assign dout = second_reg;

endmodule : sbi_sync

// file: hdl/sbi_addr_latch.sv
// Addressable output latch: one of eight bits set or cleared
`timescale 1ns/10ps
module sbi_addr_latch
  import sbi_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               clear,
  input  wire logic               load,
  input  wire sbi_request_t       req,
  output logic [SBI_LINES-1:0]    lines
);

  logic [SBI_LINES-1:0] lines_reg;

  // ----------------------------------------
  // Per-line update
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < SBI_LINES; gi++) begin : g_line
      wire logic hit;
      assign hit = load && (req.level_code == SBI_LEVEL_W'(gi));
      always_ff @(posedge clk) begin
        if (clear) begin
          lines_reg[gi] <= 1'b0;
        end else if (hit) begin
          lines_reg[gi] <= req.request_on_bit;
        end
      end
    end
  endgenerate

  assign lines = lines_reg;

endmodule : sbi_addr_latch

// file: verif/sbi_checker.sv
// Checker: port-level properties of the interrupt requester
`timescale 1ns/10ps
module sbi_checker
  import sbi_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       bus_vectored_mode,
  input wire logic       request_port_write,
  input wire logic       local_io_read_active,
  input wire logic       local_io_write_active,
  input wire logic       bus_ack_strobe_n,
  input wire logic [7:0] bus_int_n_o,
  input wire logic [7:0] bus_int_n_oe,
  input wire logic [7:0] bus_data_oe,
  input wire logic       ack_drive_n_o,
  input wire logic       ack_drive_n_oe,
  input wire logic       request_clear,
  input wire logic       vector_drive_active,
  input wire logic [1:0] ack_phase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_reach(logic [1:0] st); ##[1:4] ack_phase == st; endsequence
  sequence s_hold2; $stable(bus_int_n_oe)[*2]; endsequence
  chk_open_drain: assert property (bus_int_n_o == 8'h00 && !ack_drive_n_o)
    else $error("driven level not low");
  chk_data_enable: assert property (bus_data_oe == {8{vector_drive_active}})
    else $error("data enable differs from vector drive");
  chk_ack_local: assert property (local_io_read_active || local_io_write_active
    |-> ack_drive_n_oe) else $error("no ack on local io");
  chk_ack_cause: assert property (ack_drive_n_oe |-> local_io_read_active ||
    local_io_write_active || vector_drive_active) else $error("stray ack");
  chk_vec_start: assert property ($rose(vector_drive_active)
    |-> $past(ack_phase) == SBI_ACK_THREE) else $error("vector outside three");
  chk_vec_hold: assert property (vector_drive_active && !request_clear
    |=> vector_drive_active) else $error("vector dropped early");
  chk_clear_lines: assert property (request_clear
    |-> ##[1:2] bus_int_n_oe == 8'h00) else $error("lines kept after clear");
  chk_phase_one: assert property ($fell(bus_ack_strobe_n) &&
    ack_phase == SBI_ACK_IDLE |-> s_reach(SBI_ACK_ONE)) else $error("no one");
  chk_phase_two: assert property ($rose(bus_ack_strobe_n) &&
    ack_phase == SBI_ACK_ONE |-> s_reach(SBI_ACK_TWO)) else $error("no two");
  chk_phase_three: assert property ($fell(bus_ack_strobe_n) &&
    ack_phase == SBI_ACK_TWO |-> s_reach(SBI_ACK_THREE)) else $error("no 3");
  chk_apply_delay: assert property ($fell(request_port_write)
    |=> s_hold2) else $error("line changed too soon");
  chk_vec_no_off: assert property (bus_vectored_mode &&
    ($past(bus_int_n_oe) & ~bus_int_n_oe) != 8'h00
    |-> $past(request_clear)) else $error("line off in vectored mode");
endmodule : sbi_checker
bind sbi_requester sbi_checker u_chk (.clk, .reset, .bus_vectored_mode,
  .request_port_write, .local_io_read_active, .local_io_write_active,
  .bus_ack_strobe_n, .bus_int_n_o, .bus_int_n_oe, .bus_data_oe,
  .ack_drive_n_o, .ack_drive_n_oe, .request_clear, .vector_drive_active,
  .ack_phase);

// file: verif/sbi_host_model.sv
// Host model: runs bus acknowledge cycles and reads the vector
`timescale 1ns/10ps
module sbi_host_model
  import sbi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       ack_drive_n_oe,
  input  wire logic [7:0] bus_data_o,
  input  wire logic [7:0] bus_data_oe,
  output logic            bus_ack_strobe_n,
  output logic            other_ack_n,
  output logic [2:0]      bus_level_code,
  output logic            vec_valid,
  output logic [7:0]      vec_seen
);
  initial begin
    bus_ack_strobe_n = 1'b1;
    other_ack_n = 1'b1;
    bus_level_code = 3'h0;
    vec_valid = 1'b0;
    vec_seen = 8'h00;
  end
  task automatic ack_cycle(input logic [2:0] lvl);
    int n;
    @(posedge clk); #1 bus_ack_strobe_n = 1'b0;
    repeat (6) @(posedge clk); #1 bus_ack_strobe_n = 1'b1;
    repeat (6) @(posedge clk); #1 bus_level_code = lvl;
    bus_ack_strobe_n = 1'b0;
    n = 0;
    // Look off the edge so the registered drive has settled
    while (!ack_drive_n_oe && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    // Undriven data lines float up through the bus pull-ups
    vec_seen = bus_data_o | ~bus_data_oe;
    vec_valid = 1'b1;
    @(posedge clk); #1 vec_valid = 1'b0;
    // No answer: another board acknowledges so the phases unwind
    if (n == 20) other_ack_n = 1'b0;
    repeat (4) @(posedge clk); #1 bus_ack_strobe_n = 1'b1;
    bus_level_code = ~lvl;
    repeat (6) @(posedge clk); #1 other_ack_n = 1'b1;
  endtask : ack_cycle
endmodule : sbi_host_model

// file: verif/sbi_requester_tb.sv
// Testbench: request port, acknowledge cycles and vector readout
`timescale 1ns/10ps
module sbi_requester_tb
  import sbi_pkg::*;
;
  logic clk, reset, mode, wr, vw, rd, wa, ret_n, strobe_n, other_n, vv;
  logic [3:0] addr;
  logic [2:0] lvl, blvl;
  logic [7:0] vd, oe, prev, d_o, d_oe, vs, exp, vec;
  logic ack_oe;
  logic [7:0] lq[$], vq[$];
  int err_count, total_checks, i, seed;
  assign ret_n = other_n & ~ack_oe;
  sbi_requester dut (.clk(clk), .reset(reset), .bus_vectored_mode(mode),
    .request_port_write(wr), .local_addr_low_bits(addr), .vector_write(vw),
    .vector_data(vd), .local_io_read_active(rd), .local_io_write_active(wa),
    .bus_ack_strobe_n(strobe_n), .bus_ack_return_n(ret_n),
    .bus_level_code(blvl), .bus_int_n_o(), .bus_int_n_oe(oe),
    .bus_data_o(d_o), .bus_data_oe(d_oe), .ack_drive_n_o(),
    .ack_drive_n_oe(ack_oe), .request_clear(), .vector_drive_active(),
    .ack_phase());
  sbi_host_model host (.clk(clk), .ack_drive_n_oe(ack_oe), .bus_data_o(d_o),
    .bus_data_oe(d_oe), .bus_ack_strobe_n(strobe_n), .other_ack_n(other_n),
    .bus_level_code(blvl), .vec_valid(vv), .vec_seen(vs));
  always #5 clk = ~clk;
  task chk(input logic [7:0] got, input logic [7:0] want);
    total_checks++;
    if (got !== want) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task conclude;
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  task wr_req(input logic [3:0] a);
    @(posedge clk); #1 wr = 1'b1; addr = a;
    @(posedge clk); #1 wr = 1'b0; addr = ~a;
    repeat (6) @(posedge clk);
  endtask : wr_req
  // Every line change must match the oldest expected pattern
  // Falling edge: lines launched on the rising edge have settled
  always @(negedge clk) begin
    if (!reset && oe !== prev) begin
      if (lq.size() == 0) chk(oe, prev);
      else chk(oe, lq.pop_front());
    end
    prev <= oe;
    if (vv) begin
      if (vq.size() == 0) chk(vs, 8'hEE);
      else chk(vs, vq.pop_front());
    end
  end
  initial begin
    {clk, mode, wr, vw, rd, wa} = 6'h00;
    {addr, vd, exp, prev} = 28'h0;
    reset = 1'b1;
    err_count = 0;
    total_checks = 0;
    seed = $urandom(32'h7F95);
    repeat (3) @(posedge clk); #1 reset = 1'b0;
    for (i = 0; i < 16; i++) begin
      exp[i % 8] = (i < 8);
      lq.push_back(exp);
      wr_req({i < 8, 3'(i)});
    end
    for (i = 0; i < 2; i++) begin
      @(posedge clk); #1 {rd, wa} = i ? 2'b10 : 2'b01;
      #2 chk({7'h00, ack_oe}, 8'h01);
      @(posedge clk); #1 {rd, wa} = 2'b00;
    end
    mode = 1'b1;
    wr_req(4'h3);
    for (i = 0; i < 2; i++) begin
      lvl = 3'($urandom);
      vec = 8'($urandom) & 8'h7F;
      @(posedge clk); #1 vw = 1'b1; vd = vec;
      @(posedge clk); #1 vw = 1'b0; vd = ~vec;
      exp = 8'h00;
      exp[lvl] = 1'b1;
      lq.push_back(exp);
      wr_req({1'b1, lvl});
      if (i == 0) begin
        vq.push_back(8'hFF);
        host.ack_cycle(lvl ^ 3'h1);
      end
      vq.push_back(vec);
      lq.push_back(8'h00);
      host.ack_cycle(lvl);
    end
    lq.push_back(8'h20);
    wr_req(4'hD);
    @(posedge clk); #1 reset = 1'b1;
    repeat (2) @(posedge clk); #1 reset = 1'b0;
    chk(oe, 8'h00);
    repeat (4) @(posedge clk);
    chk(8'(lq.size() + vq.size()), 8'h00);
    conclude();
  end
endmodule : sbi_requester_tb
